/* sar_adc_pkg.sv */
// package of register map, fields and timing constants for the sar sequencer
package sar_adc_pkg;
  localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h6c;
  localparam logic [7:0] SETUP_OFFSET       = 8'h6d;
  localparam logic [7:0] RESULT_HIGH_OFFSET = 8'h6e;
  localparam logic [7:0] RESULT_LOW_OFFSET  = 8'h6f;
  localparam logic [7:0] AMP_ROUTE_OFFSET   = 8'h70;
  localparam logic [7:0] CTRL_STATUS_RESET  = 8'h00;
  localparam logic [7:0] SETUP_RESET        = 8'h00;
  // control/status field positions
  localparam int CS_CHAN_MSB  = 7;
  localparam int CS_CHAN_LSB  = 4;
  localparam int CS_DONE_BIT  = 3;
  localparam int CS_BUSY_BIT  = 2;
  localparam int CS_REFSW_BIT = 1;
  localparam int CS_START_BIT = 0;
  // setup field positions
  localparam int SU_PREC8_BIT = 7;
  localparam int SU_SAMP_MSB  = 6;
  localparam int SU_SAMP_LSB  = 5;
  localparam int SU_TSRC_BIT  = 4;
  localparam int SU_IRQE_BIT  = 3;
  localparam int SU_CONT_BIT  = 2;
  localparam int SU_DIV_MSB   = 1;
  localparam int SU_DIV_LSB   = 0;
  localparam int AR_ROUTE_BIT = 0;
  localparam int RESULT_BITS  = 10;
  localparam logic [4:0] AMP_CHANNEL = 5'h10;
  // sampling length in input-clock periods, per sampling select code
  localparam logic [4:0] SAMP_CODE0 = 5'h04;
  localparam logic [4:0] SAMP_CODE1 = 5'h07;
  localparam logic [4:0] SAMP_CODE2 = 5'h0a;
  localparam logic [4:0] SAMP_CODE3 = 5'h10;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_type;
endpackage

/* sar_clock_tick.sv */
`timescale 1ns/1ps
// prescaler tick generator giving the converter input-clock enable
module sar_clock_tick (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // divide select: 1, 2, 4 or 8
  input  wire logic [1:0] div_sel_i,
  // one-cycle tick at the selected rate
  output logic            tick_o
);
  logic [2:0] count_reg;
  logic [2:0] mask;

  always_comb begin
    case (div_sel_i)
      2'b00:   mask = 3'h0;
      2'b01:   mask = 3'h1;
      2'b10:   mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= 3'h0;
    end else begin
      count_reg <= count_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= ((count_reg & mask) == mask);
    end
  end
endmodule // sar_clock_tick

/* sar_adc_sequencer.sv */
// sequencer and registers of a 10-bit successive approximation converter
// Function
// - one 10-bit result per conversion
// - decide bits msb to lsb from comparator
// - set done flag when conversion ends
// - start by software, timer or trigger pin
// - 10-bit: two high bits, eight low bits
// - 8-bit mode: upper eight bits in low
// - sample and hold right after start
// - trigger source select only when continuous
// - run from prescaler clock, not oscillator
// - sixteen channels, one routed per conversion
// - unselected analog pins stay general purpose
// - conversion speed programmable by software
// - amplifier selectable as channel sixteen
// - done cleared by zero, rmw reads one
// - software start while busy restarts, reads zero
// - software start ignored when continuous
// - irq only when done and enable
`timescale 1ns/1ps
module sar_adc_sequencer
  import sar_adc_pkg::*;
#(
  parameter int RESULT_WIDTH = sar_adc_pkg::RESULT_BITS
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       rmw_i,
  output logic [7:0]      rdata_o,
  // trigger inputs from pins and timer
  input  wire logic       external_trigger_pin_i,
  input  wire logic       composite_timer_output_i,
  // analog front end
  input  wire logic       comparator_i,
  output logic [4:0]      channel_o,
  output logic            sample_hold_o,
  output logic [9:0]      dac_code_o,
  output logic            reference_switch_control_o,
  output logic            conversion_busy_o,
  // interrupt request
  output logic            irq_o
);
  import sar_adc_pkg::*;

  logic       rst_meta_reg;
  logic       rst_sync_reg;
  logic [2:0] ext_sync_reg;
  logic [2:0] tim_sync_reg;
  logic       ext_level_reg;
  logic       tim_level_reg;
  logic       trig_prev_reg;
  logic       ext_agree;
  logic       tim_agree;
  logic       trig_sel;
  logic       trig_rise;

  logic [3:0] channel_select_reg;
  logic       conversion_done_flag_reg;
  logic       reference_switch_reg;
  logic [7:0] setup_reg;
  logic       amplifier_route_select_reg;
  logic [1:0] result_high_reg;
  logic [7:0] result_low_reg;

  seq_state_type state_reg;
  logic [4:0]    samp_count_reg;
  logic [3:0]    bit_index_reg;
  logic [9:0]    sar_reg;
  logic [9:0]    trial;
  logic [4:0]    samp_len;
  logic          tick;
  logic          cont_mode;
  logic          sw_start;
  logic          start;
  logic          finish;
  logic          done_clear;
  logic          decide;

  // reset release through two flip-flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // prescaled input clock enable, speed chosen by software
  sar_clock_tick u_tick (
    .clk_i     (clk_i),
    .rst_n_i   (rst_sync_reg),
    .div_sel_i (setup_reg[SU_DIV_MSB:SU_DIV_LSB]),
    .tick_o    (tick)
  );

  // trigger inputs pass three flip-flops
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ext_sync_reg <= 3'h0;
      tim_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], external_trigger_pin_i};
      tim_sync_reg <= {tim_sync_reg[1:0], composite_timer_output_i};
    end
  end

  assign ext_agree = (ext_sync_reg[1] == ext_sync_reg[2]);
  assign tim_agree = (tim_sync_reg[1] == tim_sync_reg[2]);

  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ext_level_reg <= 1'b0;
      tim_level_reg <= 1'b0;
    end else begin
      if (ext_agree) begin
        ext_level_reg <= ext_sync_reg[2];
      end
      if (tim_agree) begin
        tim_level_reg <= tim_sync_reg[2];
      end
    end
  end

  assign cont_mode = setup_reg[SU_CONT_BIT];
  // source select matters only in continuous mode
  assign trig_sel = setup_reg[SU_TSRC_BIT] ? tim_level_reg
                                           : ext_level_reg;

  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_sel;
    end
  end

  // strobe and address decode shared by the start and clear paths
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] offset);
    reg_hit = strobe && (addr == offset);
  endfunction

  assign trig_rise = cont_mode && trig_sel && !trig_prev_reg;
  assign sw_start  = reg_hit(wr_i, addr_i, CTRL_STATUS_OFFSET)
                     && wdata_i[CS_START_BIT]
                     && !cont_mode;
  // a software start restarts a running conversion
  assign start     = sw_start
                     || (trig_rise && state_reg == ST_IDLE);
  assign done_clear = reg_hit(wr_i, addr_i, CTRL_STATUS_OFFSET)
                      && !wdata_i[CS_DONE_BIT];

  always_comb begin
    case (setup_reg[SU_SAMP_MSB:SU_SAMP_LSB])
      2'b00:   samp_len = SAMP_CODE0;
      2'b01:   samp_len = SAMP_CODE1;
      2'b10:   samp_len = SAMP_CODE2;
      default: samp_len = SAMP_CODE3;
    endcase
  end

  // trial code: keep decided bits, set the bit under test
  always_comb begin
    trial = sar_reg;
    trial[bit_index_reg] = 1'b1;
  end

  // decide a bit only once its trial code stands at the comparator;
  // at divide one this costs a second cycle per bit
  assign decide = tick && (dac_code_o == trial);

  assign finish = (state_reg == ST_CONVERT) && decide
                  && (bit_index_reg == 4'h0);

  // sequencer state
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg      <= ST_IDLE;
      samp_count_reg <= 5'h00;
      bit_index_reg  <= 4'h0;
      sar_reg        <= 10'h000;
    end else if (start) begin
      // a restart drops the partial code; results keep the last value
      state_reg      <= ST_SAMPLE;
      samp_count_reg <= 5'h00;
      bit_index_reg  <= 4'(RESULT_WIDTH - 1);
      sar_reg        <= 10'h000;
    end else begin
      case (state_reg)
        ST_SAMPLE: begin
          // hold the input for the programmed number of ticks
          if (tick) begin
            if (samp_count_reg == samp_len - 5'h01) begin
              state_reg <= ST_CONVERT;
            end else begin
              samp_count_reg <= samp_count_reg + 5'h01;
            end
          end
        end
        ST_CONVERT: begin
          if (decide) begin
            // comparator high means input at or above trial
            sar_reg[bit_index_reg] <= comparator_i;
            if (bit_index_reg == 4'h0) begin
              state_reg <= ST_IDLE;
            end else begin
              bit_index_reg <= bit_index_reg - 4'h1;
            end
          end
        end
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // both result registers load in the same edge at the end
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      result_high_reg <= 2'h0;
      result_low_reg  <= 8'h00;
    end else if (finish) begin
      if (setup_reg[SU_PREC8_BIT]) begin
        result_high_reg <= 2'h0;
        result_low_reg  <= sar_reg[9:2];
      end else begin
        result_high_reg <= sar_reg[9:8];
        result_low_reg  <= {sar_reg[7:1], comparator_i};
      end
    end
  end

  // done flag: set wins over a clearing write
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      conversion_done_flag_reg <= CTRL_STATUS_RESET[CS_DONE_BIT];
    end else if (finish) begin
      conversion_done_flag_reg <= 1'b1;
    end else if (done_clear) begin
      conversion_done_flag_reg <= 1'b0;
    end
  end

  // software control fields
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      channel_select_reg   <= CTRL_STATUS_RESET[CS_CHAN_MSB:CS_CHAN_LSB];
      reference_switch_reg <= CTRL_STATUS_RESET[CS_REFSW_BIT];
      setup_reg            <= SETUP_RESET;
      amplifier_route_select_reg <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        CTRL_STATUS_OFFSET: begin
          channel_select_reg   <= wdata_i[CS_CHAN_MSB:CS_CHAN_LSB];
          reference_switch_reg <= wdata_i[CS_REFSW_BIT];
        end
        SETUP_OFFSET: begin
          setup_reg <= wdata_i;
        end
        AMP_ROUTE_OFFSET: begin
          amplifier_route_select_reg <= wdata_i[AR_ROUTE_BIT];
        end
        default: begin
          setup_reg <= setup_reg;
        end
      endcase
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        CTRL_STATUS_OFFSET: begin
          rdata_o <= {channel_select_reg,
                      conversion_done_flag_reg || rmw_i,
                      state_reg != ST_IDLE,
                      reference_switch_reg,
                      1'b0};
        end
        SETUP_OFFSET:       rdata_o <= setup_reg;
        RESULT_HIGH_OFFSET: rdata_o <= {6'h00, result_high_reg};
        RESULT_LOW_OFFSET:  rdata_o <= result_low_reg;
        AMP_ROUTE_OFFSET:   rdata_o <= {7'h00, amplifier_route_select_reg};
        default:            rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // analog side outputs, all registered
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      channel_o                  <= 5'h00;
      sample_hold_o              <= 1'b0;
      dac_code_o                 <= 10'h000;
      reference_switch_control_o <= 1'b0;
    end else begin
      // only the selected channel is switched; others remain ports
      channel_o <= amplifier_route_select_reg ? AMP_CHANNEL
                   : {1'b0, channel_select_reg};
      sample_hold_o <= start || (state_reg == ST_SAMPLE && !(tick
                       && samp_count_reg == samp_len - 5'h01));
      // no trial code while sampling, on a restart or after the last bit
      dac_code_o <= (state_reg == ST_CONVERT && !start && !finish)
                    ? trial : 10'h000;
      reference_switch_control_o <= reference_switch_reg;
    end
  end

  // status outputs track the sequencer and the done flag
  always_ff @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      conversion_busy_o <= 1'b0;
      irq_o             <= 1'b0;
    end else begin
      conversion_busy_o <= start
                           || (state_reg != ST_IDLE && !finish);
      irq_o <= (conversion_done_flag_reg || finish) && !(done_clear && !finish)
               && setup_reg[SU_IRQE_BIT];
    end
  end
endmodule // sar_adc_sequencer

/* sar_front_end_model.sv */
// behavioural analog front end: pin levels, hold stage and comparator
`timescale 1ns/1ps
module sar_front_end_model (
  // clock
  input  wire logic             clk_i,
  // pin levels and converter controls
  input  wire logic [16:0][9:0] levels_i,
  input  wire logic [4:0]       channel_i,
  input  wire logic             sample_hold_i,
  input  wire logic [9:0]       dac_code_i,
  // comparator decision
  output logic                  comparator_o
);
  logic [9:0] held_reg = 10'h000;
  // follow the routed pin while sampling, frozen afterwards
  always_ff @(posedge clk_i) begin
    if (sample_hold_i) begin
      held_reg <= levels_i[channel_i];
    end
  end
  assign comparator_o = held_reg >= dac_code_i;
endmodule // sar_front_end_model

/* sar_adc_sequencer_properties.sv */
// port assertions for the sar conversion sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_chk
  import sar_adc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       rmw_i,
  input wire logic [7:0] rdata_o,
  input wire logic       sample_hold_o,
  input wire logic [9:0] dac_code_o,
  input wire logic       conversion_busy_o,
  input wire logic       irq_o
);
  logic cont_reg;
  logic irqe_reg;
  logic sw_start;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  assign sw_start = wr_i && addr_i == CTRL_STATUS_OFFSET && wdata_i[0];
  // shadow of the setup bits that steer starts and requests
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cont_reg <= 1'b0;
      irqe_reg <= 1'b0;
    end else if (wr_i && addr_i == SETUP_OFFSET) begin
      cont_reg <= wdata_i[SU_CONT_BIT];
      irqe_reg <= wdata_i[SU_IRQE_BIT];
    end
  end
  a_start_busy_sample: assert property (
    sw_start && !cont_reg |=> conversion_busy_o && sample_hold_o)
    else $error("software start did not begin sampling");
  a_cont_start_ignored: assert property (
    sw_start && cont_reg && !conversion_busy_o |=> !conversion_busy_o)
    else $error("software start accepted in continuous mode");
  a_sample_no_trial: assert property (
    sample_hold_o |-> dac_code_o == 10'h000)
    else $error("trial code driven while sampling");
  a_idle_no_trial: assert property (
    !conversion_busy_o |-> dac_code_o == 10'h000)
    else $error("trial code driven while idle");
  a_start_reads_zero: assert property (
    rd_i && addr_i == CTRL_STATUS_OFFSET |=> !rdata_o[CS_START_BIT])
    else $error("start bit read back as one");
  a_rmw_done_one: assert property (
    rd_i && rmw_i && addr_i == CTRL_STATUS_OFFSET |=> rdata_o[CS_DONE_BIT])
    else $error("modify read of done flag not one");
  a_irq_masked: assert property (
    !irqe_reg && !$past(irqe_reg) |-> !irq_o)
    else $error("request raised while disabled");
  a_busy_bounded: assert property (
    $rose(conversion_busy_o) |-> ##[1:700] !conversion_busy_o)
    else $error("conversion never completed");
  a_done_raises_irq: assert property (
    $fell(conversion_busy_o) && irqe_reg |-> ##[0:1] irq_o)
    else $error("completion raised no request");
endmodule // sar_adc_sequencer_chk

bind sar_adc_sequencer sar_adc_sequencer_chk u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rmw_i(rmw_i), .rdata_o(rdata_o),
  .sample_hold_o(sample_hold_o), .dac_code_o(dac_code_o),
  .conversion_busy_o(conversion_busy_o), .irq_o(irq_o));

/* tb_sar_adc_sequencer.sv */
// self-checking bench for the sar conversion sequencer
`timescale 1ns/1ps
module tb_sar_adc_sequencer;
  import sar_adc_pkg::*;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rmw_i = 0, cmp;
  logic trg_pin = 0, trg_tmr = 0, sh, busy, irq, refsw;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, r;
  logic [4:0] chan, ch;
  logic [9:0] dac, v;
  logic [16:0][9:0] lv = '0;
  int err_count = 0, num_checks = 0, seed = 24, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  sar_adc_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rmw_i(rmw_i), .rdata_o(rdata_o), .external_trigger_pin_i(trg_pin),
    .composite_timer_output_i(trg_tmr), .comparator_i(cmp),
    .channel_o(chan), .sample_hold_o(sh), .dac_code_o(dac),
    .reference_switch_control_o(refsw), .conversion_busy_o(busy),
    .irq_o(irq));
  sar_front_end_model u_fe (.clk_i(clk_i), .levels_i(lv),
    .channel_i(chan), .sample_hold_i(sh), .dac_code_i(dac),
    .comparator_o(cmp));
  task automatic test_done();
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic m,
                       input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    rmw_i <= m;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    rmw_i <= 1'b0;
    #1 check(16'(rdata_o), 16'(e));
  endtask
  task automatic rnd();
    for (int i = 0; i < 17; i++) lv[i] = 10'($random(seed));
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 900) begin
      @(posedge clk_i);
      #1 n++;
    end
    check(16'(n < 900), 16'h1);
  endtask
  // capture the held level at the end of sampling, then move the pins
  task automatic follow(input logic [4:0] c);
    int n;
    n = 0;
    while (sh !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1 n++;
    end
    while (sh !== 1'b0 && n < 400) begin
      @(posedge clk_i);
      #1 n++;
    end
    v = lv[c];
    check(16'(chan), 16'(c));
    rnd();
    idle();
  endtask
  task automatic conv(input logic [4:0] c, input logic [7:0] su);
    wr(AMP_ROUTE_OFFSET, {7'h00, c[4]});
    wr(SETUP_OFFSET, su & 8'hfb);
    wr(CTRL_STATUS_OFFSET, {c[3:0], 4'h1});
    follow(c);
    check(16'(irq), 16'(su[3]));
    rdchk(RESULT_HIGH_OFFSET, 0, su[7] ? 8'h00 : {6'h00, v[9:8]});
    rdchk(RESULT_LOW_OFFSET, 0, su[7] ? v[9:2] : v[7:0]);
    wr(CTRL_STATUS_OFFSET, {c[3:0], 4'h8});
    rdchk(CTRL_STATUS_OFFSET, 0, {c[3:0], 4'h8});
    wr(CTRL_STATUS_OFFSET, {c[3:0], 4'h0});
    rdchk(CTRL_STATUS_OFFSET, 1, {c[3:0], 4'h8});
    rdchk(CTRL_STATUS_OFFSET, 0, {c[3:0], 4'h0});
    check(16'(irq), 16'h0);
  endtask
  task automatic pulse(input logic tm, input logic e);
    @(posedge clk_i);
    trg_tmr <= tm;
    trg_pin <= !tm;
    repeat (8) @(posedge clk_i);
    trg_tmr <= 1'b0;
    trg_pin <= 1'b0;
    #1 check(16'(busy), 16'(e));
    idle();
  endtask
  // thirteen conversions at most a few hundred cycles each, plus setup
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    rnd();
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdchk(CTRL_STATUS_OFFSET, 0, CTRL_STATUS_RESET);
    rdchk(SETUP_OFFSET, 0, SETUP_RESET);
    wr(RESULT_LOW_OFFSET, 8'hff);
    rdchk(RESULT_LOW_OFFSET, 0, 8'h00);
    rdchk(8'h55, 0, 8'h00);
    wr(CTRL_STATUS_OFFSET, 8'h0a);
    @(posedge clk_i);
    #1 check(16'(refsw), 16'h1);
    rdchk(CTRL_STATUS_OFFSET, 0, 8'h02);
    for (int k = 0; k < 10; k++) begin
      r = 8'($random(seed));
      ch = k == 0 ? 5'h10 : k == 1 ? 5'h0f : 5'($unsigned(r) % 17);
      conv(ch, {r[7], 2'(k >> 1), 1'b0, r[3], 1'b0, 2'(k)});
    end
    wr(AMP_ROUTE_OFFSET, 8'h00);
    wr(SETUP_OFFSET, 8'h08);
    wr(CTRL_STATUS_OFFSET, 8'h51);
    repeat (8) @(posedge clk_i);
    rnd();
    v = lv[5];
    wr(CTRL_STATUS_OFFSET, 8'h51);
    follow(5'h05);
    rdchk(RESULT_LOW_OFFSET, 0, v[7:0]);
    // trigger pin assumed configured as an input
    wr(SETUP_OFFSET, 8'h04);
    wr(CTRL_STATUS_OFFSET, 8'h31);
    repeat (6) @(posedge clk_i);
    #1 check(16'(busy), 16'h0);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    v = lv[3];
    rdchk(RESULT_LOW_OFFSET, 0, v[7:0]);
    wr(SETUP_OFFSET, 8'h14);
    pulse(1'b0, 1'b0);
    pulse(1'b1, 1'b1);
    test_done();
  end
endmodule // tb_sar_adc_sequencer
